// file: design/cws_pkg.sv
// Constants for the channel write select register of the serial control port.
// Assumes a serial port front end that delivers whole decoded byte writes.
package cws_pkg;
   localparam logic [4:0] CWS_ADDR_SELECT    = 5'h00;
   localparam logic [4:0] CWS_ADDR_CHAN_LO   = 5'h03;
   localparam logic [4:0] CWS_ADDR_CHAN_HI   = 5'h18;
   localparam int         CWS_EN_LSB         = 4;
   localparam int         CWS_EN_MSB         = 7;
   localparam int         CWS_ZERO_BIT       = 3;
   localparam int         CWS_MODE_LSB       = 1;
   localparam int         CWS_MODE_MSB       = 2;
   localparam int         CWS_ORDER_BIT      = 0;
   localparam logic [7:0] CWS_SELECT_RESET   = 8'hF0;
   localparam logic [1:0] CWS_MODE_1B_2WIRE  = 2'h0;
   localparam logic [1:0] CWS_MODE_1B_3WIRE  = 2'h1;
   localparam logic [1:0] CWS_MODE_2BIT      = 2'h2;
   localparam logic [1:0] CWS_MODE_4BIT      = 2'h3;
   localparam logic [2:0] CWS_LANES_1        = 3'h1;
   localparam logic [2:0] CWS_LANES_2        = 3'h2;
   localparam logic [2:0] CWS_LANES_4        = 3'h4;
endpackage : cws_pkg

// file: design/cws_channel_select.sv
// Channel write select register and the per-channel write routing it steers.
// Assumes the serial front end runs on CLK and delivers one pulse per finished byte
// write, and holds XFER_ACTIVE high for the whole of each serial transfer.
`timescale 1ns/10ps
`default_nettype none
module cws_channel_select #(
   parameter int NUM_CHAN = 4
) (
   input  wire logic                CLK,
   input  wire logic                RST,
   input  wire logic                WR_STB,
   input  wire logic [4:0]          WR_ADDR,
   input  wire logic [7:0]          WR_DATA,
   input  wire logic                XFER_ACTIVE,
   output var  logic [7:0]          RD_DATA,
   output var  logic [NUM_CHAN-1:0] CHAN_EN,
   output var  logic [NUM_CHAN-1:0] CHAN_WR,
   output var  logic [4:0]          CHAN_ADDR,
   output var  logic [7:0]          CHAN_DATA,
   output var  logic [1:0]          SER_MODE,
   output var  logic                THREE_WIRE,
   output var  logic [2:0]          SER_LANES,
   output var  logic                LSB_FIRST
);

   logic       sel_wr;
   logic       chan_hit;
   logic [7:0] sel_d;
   logic [2:0] lanes_d;

   // Decode of the incoming byte write.
   assign sel_wr   = WR_STB && (WR_ADDR == cws_pkg::CWS_ADDR_SELECT);
   assign chan_hit = WR_STB && (WR_ADDR >= cws_pkg::CWS_ADDR_CHAN_LO)
                     && (WR_ADDR <= cws_pkg::CWS_ADDR_CHAN_HI);

   // The must-be-zero bit is forced low so a careless write cannot leave it set.
   always_comb
   begin
      sel_d = WR_DATA;
      sel_d[cws_pkg::CWS_ZERO_BIT] = 1'b0;
   end

   // The stored byte, also what software reads back.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         RD_DATA <= cws_pkg::CWS_SELECT_RESET;
      else if (sel_wr)
         RD_DATA <= sel_d;
   end

   // Enables are their own copy and follow the write on the same edge.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
         CHAN_EN <= cws_pkg::CWS_SELECT_RESET[cws_pkg::CWS_EN_MSB:cws_pkg::CWS_EN_LSB];
      else if (sel_wr)
         CHAN_EN <= WR_DATA[cws_pkg::CWS_EN_MSB:cws_pkg::CWS_EN_LSB];
   end

   // Routing of shared-address writes to each enabled channel copy.
   generate
      for (genvar n = 0; n < NUM_CHAN; n++)
      begin : g_route
         always_ff @(posedge CLK or posedge RST)
         begin
            if (RST)
               CHAN_WR[n] <= 1'b0;
            else
               CHAN_WR[n] <= chan_hit && CHAN_EN[n];
         end
      end
   endgenerate

   // Address and data held with the strobe; they only matter while CHAN_WR is set.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         CHAN_ADDR <= 5'h00;
         CHAN_DATA <= 8'h00;
      end
      else if (chan_hit)
      begin
         CHAN_ADDR <= WR_ADDR;
         CHAN_DATA <= WR_DATA;
      end
   end

   // Lane count for the stored mode.
   always_comb
   begin
      unique case (RD_DATA[cws_pkg::CWS_MODE_MSB:cws_pkg::CWS_MODE_LSB])
         cws_pkg::CWS_MODE_1B_2WIRE: lanes_d = cws_pkg::CWS_LANES_1;
         cws_pkg::CWS_MODE_1B_3WIRE: lanes_d = cws_pkg::CWS_LANES_1;
         cws_pkg::CWS_MODE_2BIT:     lanes_d = cws_pkg::CWS_LANES_2;
         cws_pkg::CWS_MODE_4BIT:     lanes_d = cws_pkg::CWS_LANES_4;
      endcase
   end

   // Port settings are copied only while idle, so a transfer that rewrites
   // them keeps its own framing to the end; the cost is one idle cycle.
   always_ff @(posedge CLK or posedge RST)
   begin
      if (RST)
      begin
         SER_MODE   <= cws_pkg::CWS_SELECT_RESET[cws_pkg::CWS_MODE_MSB:cws_pkg::CWS_MODE_LSB];
         THREE_WIRE <= 1'b0;
         SER_LANES  <= cws_pkg::CWS_LANES_1;
         LSB_FIRST  <= cws_pkg::CWS_SELECT_RESET[cws_pkg::CWS_ORDER_BIT];
      end
      else if (!XFER_ACTIVE)
      begin
         SER_MODE   <= RD_DATA[cws_pkg::CWS_MODE_MSB:cws_pkg::CWS_MODE_LSB];
         THREE_WIRE <= (RD_DATA[cws_pkg::CWS_MODE_MSB:cws_pkg::CWS_MODE_LSB]
                        == cws_pkg::CWS_MODE_1B_3WIRE);
         SER_LANES  <= lanes_d;
         LSB_FIRST  <= RD_DATA[cws_pkg::CWS_ORDER_BIT];
      end
   end

   // Checks.
   property p_byte_store;
      @(posedge CLK) disable iff (RST)
      sel_wr |=> (RD_DATA == {$past(WR_DATA[7:4]), 1'b0, $past(WR_DATA[2:0])});
   endproperty
   a_byte_store: assert property (p_byte_store)
      else $error("select byte not stored as written");

   property p_reset_en;
      @(posedge CLK) $fell(RST) |-> (CHAN_EN == 4'hF) && (RD_DATA == 8'hF0);
   endproperty
   a_reset_en: assert property (p_reset_en)
      else $error("enables not all set after reset");

   property p_en_now;
      @(posedge CLK) disable iff (RST)
      sel_wr |=> (CHAN_EN == $past(WR_DATA[7:4]));
   endproperty
   a_en_now: assert property (p_en_now)
      else $error("enable write did not apply at once");

   property p_route;
      @(posedge CLK) disable iff (RST)
      WR_STB |=> (CHAN_WR == ($past(chan_hit) ? $past(CHAN_EN) : 4'h0));
   endproperty
   a_route: assert property (p_route)
      else $error("channel write routed to wrong copies");

   property p_mode_lanes;
      @(posedge CLK) disable iff (RST)
      (SER_LANES == ((SER_MODE == 2'h3) ? 3'h4 : (SER_MODE == 2'h2) ? 3'h2 : 3'h1))
      && (THREE_WIRE == (SER_MODE == 2'h1));
   endproperty
   a_mode_lanes: assert property (p_mode_lanes)
      else $error("serial mode decode wrong");

   property p_order_idle;
      @(posedge CLK) disable iff (RST)
      (!XFER_ACTIVE ##1 !XFER_ACTIVE) |-> (LSB_FIRST == $past(RD_DATA[0]))
      && (SER_MODE == $past(RD_DATA[2:1]));
   endproperty
   a_order_idle: assert property (p_order_idle)
      else $error("bit order not taken while idle");

   property p_hold_busy;
      @(posedge CLK) disable iff (RST)
      (XFER_ACTIVE && $past(XFER_ACTIVE)) |-> ($stable(SER_MODE) && $stable(LSB_FIRST)
      && $stable(SER_LANES));
   endproperty
   a_hold_busy: assert property (p_hold_busy)
      else $error("port settings changed during transfer");

   property p_wr_pulse;
      @(posedge CLK) disable iff (RST)
      (CHAN_WR != 4'h0) |-> (CHAN_ADDR >= cws_pkg::CWS_ADDR_CHAN_LO)
      && (CHAN_ADDR <= cws_pkg::CWS_ADDR_CHAN_HI);
   endproperty
   a_wr_pulse: assert property (p_wr_pulse)
      else $error("channel strobe with address outside channel range");

   // The copies must see exactly the byte and address that were written.
   property p_chan_copy;
      @(posedge CLK) disable iff (RST)
      chan_hit |=> (CHAN_ADDR == $past(WR_ADDR)) && (CHAN_DATA == $past(WR_DATA));
   endproperty
   a_chan_copy: assert property (p_chan_copy)
      else $error("channel address or data not passed on");

   // A write to any other address must leave the select byte alone.
   property p_stray;
      @(posedge CLK) disable iff (RST)
      (WR_STB && !sel_wr) |=> ($stable(RD_DATA) && $stable(CHAN_EN));
   endproperty
   a_stray: assert property (p_stray)
      else $error("select byte changed by another address");

   // The must-be-zero bit never reads back set.
   property p_zero_bit;
      @(posedge CLK) disable iff (RST)
      (RD_DATA[cws_pkg::CWS_ZERO_BIT] == 1'b0);
   endproperty
   a_zero_bit: assert property (p_zero_bit)
      else $error("must-be-zero bit reads back set");

   // Coming out of reset the port shifts one wire, most significant bit first.
   property p_reset_port;
      @(posedge CLK) $fell(RST) |-> (SER_MODE == cws_pkg::CWS_MODE_1B_2WIRE)
      && !LSB_FIRST && !THREE_WIRE && (CHAN_WR == 4'h0);
   endproperty
   a_reset_port: assert property (p_reset_port)
      else $error("port settings wrong after reset");

   // A select write inside a transfer must not reframe that transfer.
   property p_busy_write;
      @(posedge CLK) disable iff (RST)
      (XFER_ACTIVE && sel_wr) |=> ($stable(SER_MODE) && $stable(LSB_FIRST)
      && $stable(THREE_WIRE));
   endproperty
   a_busy_write: assert property (p_busy_write)
      else $error("port settings changed by a write during transfer");

endmodule : cws_channel_select
`default_nettype wire

// file: tb/cws_host_model.sv
// Host side model that hands finished byte writes to the select block.
// Assumes its tasks are called at the falling edge of CLK.
`timescale 1ns/10ps
`default_nettype none
module cws_host_model (
   input  wire logic       CLK,
   output var  logic       STB,
   output var  logic [4:0] ADDR,
   output var  logic [7:0] DATA,
   output var  logic       XACT
);
   // Idle state at time zero, released lines already inverted.
   initial
   begin
      STB = 1'h0;
      ADDR = 5'h1F;
      DATA = 8'hFF;
      XACT = 1'h0;
   end
   // Holds the write through its taking edge; calls may follow back to back.
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      STB = 1'h1;
      ADDR = a;
      DATA = d;
      @(negedge CLK);
   endtask : wr
   // Released lines invert so a stale byte cannot pass for fresh data.
   task automatic idle();
      STB = 1'h0;
      ADDR = ~ADDR;
      DATA = ~DATA;
      @(negedge CLK);
   endtask : idle
   // Opens or closes a serial transfer.
   task automatic xa(input logic v);
      XACT = v;
      @(negedge CLK);
   endtask : xa
endmodule : cws_host_model
`default_nettype wire

// file: tb/channel_select_register_tb_top.sv
// Self-checking bench for the channel write select register.
// Assumes the host model drives every write input of the block.
`timescale 1ns/10ps
`default_nettype none
module channel_select_register_tb_top;
   logic       clk = 1'h0;
   logic       rst = 1'h1;
   logic       stb, xact, three, lsb;
   logic [4:0] addr, c_addr;
   logic [7:0] data, rd, c_data;
   logic [3:0] en, cwr;
   logic [1:0] mode;
   logic [2:0] lanes;
   int         bad_count = 0;
   int         num_checks = 0;
   always #5 clk = ~clk;
   cws_host_model h (.CLK(clk), .STB(stb), .ADDR(addr), .DATA(data), .XACT(xact));
   cws_channel_select u_dut (.CLK(clk), .RST(rst), .WR_STB(stb), .WR_ADDR(addr),
      .WR_DATA(data), .XFER_ACTIVE(xact), .RD_DATA(rd), .CHAN_EN(en), .CHAN_WR(cwr),
      .CHAN_ADDR(c_addr), .CHAN_DATA(c_data), .SER_MODE(mode), .THREE_WIRE(three),
      .SER_LANES(lanes), .LSB_FIRST(lsb));
   // Counts every comparison and reports a difference at once.
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      num_checks++;
      if (s !== e)
      begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   // Compares the live port settings with a mode and a bit order.
   task automatic chk_port(input logic [1:0] m, input logic o);
      chk("ser_mode", mode, m);
      chk("three_wire", three, m == 2'h1);
      chk("lanes", lanes, m == 2'h3 ? 3'h4 : m == 2'h2 ? 3'h2 : 3'h1);
      chk("lsb_first", lsb, o);
   endtask : chk_port
   // Back to back select and channel writes, the bit 3 drop and a stray address.
   task automatic t_route();
      h.wr(5'h00, 8'h9B);
      chk("rd_data", rd, 8'h93);
      chk("chan_en", en, 4'h9);
      h.wr(5'h0A, 8'h5A);
      chk("chan_wr", cwr, 4'h9);
      chk("chan_data", c_data, 8'h5A);
      h.wr(5'h00, 8'h20);
      h.wr(5'h18, 8'hC3);
      chk("chan_wr", cwr, 4'h2);
      chk("chan_addr", c_addr, 8'h18);
      h.wr(5'h1F, 8'h00);
      chk("chan_wr", cwr, 4'h0);
      chk("rd_data", rd, 8'h20);
      h.wr(5'h03, 8'h11);
      chk("chan_wr", cwr, 4'h2);
      h.wr(5'h02, 8'h22);
      chk("chan_wr", cwr, 4'h0);
      chk("chan_data", c_data, 8'h11);
      chk("chan_addr", c_addr, 8'h03);
      h.idle();
   endtask : t_route
   // Every serial mode taken while idle, the bit order set to the mode's low bit.
   task automatic t_modes();
      for (int m = 0; m < 4; m++)
      begin
         h.wr(5'h00, {4'hF, 1'h0, 2'(m), 1'(m & 1)});
         h.idle();
         chk_port(2'(m), 1'(m & 1));
      end
   endtask : t_modes
   // A write inside a transfer waits for the transfer to end.
   task automatic t_hold();
      h.xa(1'h1);
      h.wr(5'h00, 8'hF0);
      h.idle();
      chk_port(2'h3, 1'h1);
      h.xa(1'h0);
      chk_port(2'h0, 1'h0);
   endtask : t_hold
   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_sim
   // Main sequence after five reset cycles; a watchdog cuts a hang short.
   initial
   begin
      repeat (5) @(negedge clk);
      rst = 1'h0;
      chk("rd_data", rd, 8'hF0);
      chk("chan_en", en, 4'hF);
      chk_port(2'h0, 1'h0);
      t_route();
      t_modes();
      t_hold();
      end_sim();
   end
   initial
   begin
      #100000;
      bad_count++;
      end_sim();
   end
endmodule : channel_select_register_tb_top
`default_nettype wire
